//--- lcr_chk.sv
// Assertion checker for the parallel bus between host end and both halves.
`timescale 1ns/1ps
module lcr_chk (
	input wire logic       ref_clk,
	input wire logic       nrst,
	input wire logic       transfer_select_pin,
	input wire logic       strobe,
	input wire logic       read_write,
	input wire logic       left_half_select,
	input wire logic       right_half_select,
	input wire logic       host_byte_oe,
	input wire logic [1:0] dev_byte_oe
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	// ======
	// Helper counters
	// ======
	logic [7:0] high_q; // Cycles the strobe has stood high.
	logic [7:0] gap_q;  // Cycles since the last strobe rise, saturating.
	logic       sel;    // Either half selected.
	assign sel = left_half_select | right_half_select;

	// In reset high_q clears and gap_q saturates, so a cut cycle is never measured.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			high_q <= 8'h00;
			gap_q  <= 8'hff;
		end else begin
			high_q <= strobe ? high_q + 8'h01 : 8'h00;
			if ($rose(strobe)) begin
				gap_q <= 8'h01;
			end else if (gap_q != 8'hff) begin
				gap_q <= gap_q + 8'h01;
			end
		end
	end

	// ======
	// Assertions
	// ======
	AST_DEV_READ: assert property (|dev_byte_oe |-> read_write)
		else $error("half drives lines outside a read");
	AST_HOST_WRITE: assert property (host_byte_oe |-> !read_write)
		else $error("host drives lines during a read");
	AST_ONE_DRIVER: assert property (!(host_byte_oe && |dev_byte_oe))
		else $error("data lines driven from both sides");
	AST_LEFT_SEL: assert property (dev_byte_oe[0] |-> left_half_select)
		else $error("left half drives while unselected");
	AST_RIGHT_SEL: assert property (dev_byte_oe[1] |-> right_half_select)
		else $error("right half drives while unselected");
	AST_WRITE_DRIVE: assert property (strobe && !read_write |-> host_byte_oe)
		else $error("write strobe without host data");
	AST_WIDTH: assert property ($fell(strobe) |->
		high_q == (read_write ? lcr_pkg::RD_CYC : lcr_pkg::WR_CYC))
		else $error("strobe width wrong");
	AST_SETUP: assert property ($rose(strobe) |-> $past(sel, 5)
		&& $stable(read_write) && $stable(transfer_select_pin))
		else $error("select set-up too short");
	AST_HOLD: assert property ($fell(strobe) |-> (sel && $stable(read_write))[*3])
		else $error("select hold too short");
	AST_CYCLE: assert property ($rose(strobe) |-> gap_q >= lcr_pkg::TCYC_CYC)
		else $error("bus cycles too close");

	// Main scenarios seen on the wire.
	COV_WRITE: cover property ($fell(strobe) && !read_write);
	COV_LEFT_READ: cover property (dev_byte_oe[0]);
	COV_RIGHT_READ: cover property (dev_byte_oe[1]);

endmodule : lcr_chk

//--- lcr_device.sv
// Command decoder and control registers of one half controller.
`timescale 1ns/1ps
module lcr_device #(
	parameter int HALF = 0 // 0: left half, 1: right half.
) (
	input  wire logic ref_clk,
	input  wire logic nrst,
	input  wire logic clk_en,
	lcr_if.dev        bus,
	output logic      display_enable,
	output logic      outputs_at_supply,
	output logic [5:0] first_row_pointer,
	output logic [2:0] page_pointer,
	output logic [6:0] column_pointer,
	output logic      low_power_static,
	output logic      duty_choice,
	output logic      segment_order,
	output logic [7:0] controller_status
);

	// ==========================================================================
	// Pin synchronisation
	// ==========================================================================
	// The pins belong to the host, so all of them cross two flip-flops first.
	// The price is a few cycles of latency, far inside the strobe width.
	logic [11:0] pins_raw;  // Raw pins in a fixed order.
	logic [11:0] pins_sync; // Same pins after the synchroniser.
	logic        sel_raw;   // This half's chip select, raw.

	assign sel_raw  = (HALF == 0) ? bus.left_half_select : bus.right_half_select;
	assign pins_raw = {bus.host_byte_lines, sel_raw, bus.transfer_select_pin,
		bus.read_write, bus.strobe};

	lcr_sync #(.W(12)) u_sync (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.clk_en  (clk_en),
		.d       (pins_raw),
		.q       (pins_sync)
	);

	logic [7:0] byte_s; // Synchronised data lines.
	logic       sel_s;  // Synchronised chip select.
	logic       tsel_s; // Synchronised transfer select.
	logic       rw_s;   // Synchronised read/write.
	logic       stb_s;  // Synchronised strobe.

	assign {byte_s, sel_s, tsel_s, rw_s, stb_s} = pins_sync;

	// ==========================================================================
	// State
	// ==========================================================================
	typedef struct packed {
		logic       stb_prev;  // Strobe one cycle ago, for the trailing edge.
		logic [7:0] cap_byte;  // Data lines captured while the strobe is high.
		logic       cap_tsel;  // Transfer select captured with the byte.
		logic       cap_rw;    // Read/write captured with the byte.
		logic       cap_sel;   // Chip select captured with the byte.
		logic       enable;    // Display enable register.
		logic [5:0] row;       // First displayed row.
		logic [2:0] page;      // Memory page pointer.
		logic [6:0] col;       // Column pointer.
		logic       stat;      // Low-power static drive.
		logic       duty;      // Duty choice.
		logic       order;     // Segment order.
		logic [3:0] busy_cnt;  // Cycles left in the busy window.
		logic [7:0] rd_byte;   // Byte presented on a read.
	} lcr_dev_s;

	lcr_dev_s s_q;
	lcr_dev_s s_d;

	logic       busy;     // High while a taken write is still being absorbed.
	logic       stb_fall; // Trailing edge of the strobe.
	logic [7:0] status;   // Live status byte.

	assign busy     = (s_q.busy_cnt != 4'h0);
	assign stb_fall = s_q.stb_prev && !stb_s;

	// Status bits mirror segment order, enable and static drive, and the busy window.
	always_comb begin
		status                       = 8'h00;
		status[lcr_pkg::ST_BUSY]     = busy;
		status[lcr_pkg::ST_MAP]      = s_q.order;
		status[lcr_pkg::ST_ENABLE]   = s_q.enable;
		status[lcr_pkg::ST_STATIC]   = s_q.stat;
	end

	// ==========================================================================
	// Next-state logic
	// ==========================================================================
	// Bytes are captured every cycle the strobe is high, so the decode at the
	// trailing edge sees what the host held, even after its short hold time.
	always_comb begin
		s_d          = s_q;
		s_d.stb_prev = stb_s;
		if (busy) begin
			s_d.busy_cnt = s_q.busy_cnt - 4'h1;
		end
		if (stb_s) begin
			s_d.cap_byte = byte_s;
			s_d.cap_tsel = tsel_s;
			s_d.cap_rw   = rw_s;
			s_d.cap_sel  = sel_s;
		end
		// Read data is loaded at the leading edge and held for the read.
		if (stb_s && !s_q.stb_prev && sel_s && rw_s) begin
			s_d.rd_byte = tsel_s ? 8'h00 : status;
		end
		// Writes and data reads complete at the trailing edge.
		if (stb_fall && s_q.cap_sel) begin
			if (s_q.cap_tsel) begin
				// Data transfer in either direction moves the column on.
				s_d.col = (s_q.col == lcr_pkg::COL_LAST) ? lcr_pkg::COL_RST
					: s_q.col + 7'h01;
				if (!s_q.cap_rw) begin
					s_d.busy_cnt = lcr_pkg::BUSY_CYC;
				end
			end else if (!s_q.cap_rw) begin
				s_d.busy_cnt = lcr_pkg::BUSY_CYC;
				if ((s_q.cap_byte & lcr_pkg::CMD_DISP_MASK) == lcr_pkg::CMD_DISP_CODE) begin
					s_d.enable = s_q.cap_byte[0];
				end else if ((s_q.cap_byte & lcr_pkg::CMD_ROW_MASK)
						== lcr_pkg::CMD_ROW_CODE) begin
					s_d.row = {1'b0, s_q.cap_byte[4:0]};
				end else if ((s_q.cap_byte & lcr_pkg::CMD_PAGE_MASK)
						== lcr_pkg::CMD_PAGE_CODE) begin
					s_d.page = {1'b0, s_q.cap_byte[1:0]};
				end else if ((s_q.cap_byte & lcr_pkg::CMD_MAP_MASK)
						== lcr_pkg::CMD_MAP_CODE) begin
					s_d.order = s_q.cap_byte[0];
				end else if ((s_q.cap_byte & lcr_pkg::CMD_STATIC_MASK)
						== lcr_pkg::CMD_STATIC_CODE) begin
					s_d.stat = s_q.cap_byte[0];
				end else if ((s_q.cap_byte & lcr_pkg::CMD_DUTY_MASK)
						== lcr_pkg::CMD_DUTY_CODE) begin
					s_d.duty = s_q.cap_byte[0];
				end else if ((s_q.cap_byte & lcr_pkg::CMD_COL_MASK)
						== lcr_pkg::CMD_COL_CODE) begin
					// Values past the last column are held to the last column.
					s_d.col = (s_q.cap_byte[6:0] > lcr_pkg::COL_LAST) ? lcr_pkg::COL_LAST
						: s_q.cap_byte[6:0];
				end else begin
					// Unknown codes change nothing but still take the busy time.
					s_d.busy_cnt = lcr_pkg::BUSY_CYC;
				end
			end
		end
	end

	// ==========================================================================
	// Registers
	// ==========================================================================
	// Reset values make the panel blank until the host programs the core.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_q          <= '0;
			s_q.enable   <= lcr_pkg::ENABLE_RST;
			s_q.row      <= lcr_pkg::ROW_RST;
			s_q.page     <= lcr_pkg::PAGE_RST;
			s_q.col      <= lcr_pkg::COL_RST;
			s_q.stat     <= lcr_pkg::STATIC_RST;
			s_q.duty     <= lcr_pkg::DUTY_RST;
			s_q.order    <= lcr_pkg::MAP_RST;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	// ==========================================================================
	// Outputs
	// ==========================================================================
	// The data lines are driven only while this half is read.
	assign bus.dev_byte_oe[HALF]  = stb_s && sel_s && rw_s;
	assign bus.dev_byte_out[HALF] = s_q.rd_byte;

	assign display_enable     = s_q.enable;
	assign outputs_at_supply  = !s_q.enable;
	assign first_row_pointer  = s_q.row;
	assign page_pointer       = s_q.page;
	assign column_pointer     = s_q.col;
	assign low_power_static   = s_q.stat;
	assign duty_choice        = s_q.duty;
	assign segment_order      = s_q.order;
	assign controller_status  = status;

endmodule : lcr_device

//--- lcr_host.sv
// Host end: turns user requests into timed cycles on the parallel bus.
`timescale 1ns/1ps
module lcr_host (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       clk_en,
	lcr_if.host             bus,
	input  wire logic       cmd_valid,
	output logic            cmd_ready,
	input  wire logic       cmd_is_data,
	input  wire logic       cmd_is_read,
	input  wire logic       cmd_half,
	input  wire logic [7:0] cmd_byte,
	output logic            rsp_valid,
	output logic [7:0]      rsp_byte
);

	// ==========================================================================
	// Data line synchronisation
	// ==========================================================================
	logic [7:0] lines_s; // Data lines after two flip-flops.

	lcr_sync #(.W(8)) u_sync (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.clk_en  (clk_en),
		.d       (bus.host_byte_lines),
		.q       (lines_s)
	);

	// ==========================================================================
	// State
	// ==========================================================================
	typedef struct packed {
		lcr_pkg::lcr_state_e st;    // Sequencer state.
		logic [7:0]          cnt;   // Cycles since the cycle began.
		logic                tsel;  // Transfer select being driven.
		logic                rd;    // Read cycle in progress.
		logic                half;  // Half being addressed.
		logic [7:0]          wbyte; // Byte being written.
		logic                rvld;  // Read answer strobe.
		logic [7:0]          rbyte; // Read answer byte.
	} lcr_host_s;

	lcr_host_s s_q;
	lcr_host_s s_d;

	logic [7:0] stb_end; // Count at which the strobe drops.

	assign stb_end = lcr_pkg::SETUP_CYC + (s_q.rd ? lcr_pkg::RD_CYC : lcr_pkg::WR_CYC);

	// ==========================================================================
	// Sequencer
	// ==========================================================================
	// Set-up, strobe, hold and the gap that fills the least cycle time.
	// Programming every register after reset is the user's task.
	always_comb begin
		s_d      = s_q;
		s_d.rvld = 1'b0;
		if (s_q.st != lcr_pkg::LCR_IDLE) begin
			s_d.cnt = s_q.cnt + 8'h01;
		end
		case (s_q.st)
			lcr_pkg::LCR_IDLE: begin
				if (cmd_valid) begin
					s_d.st    = lcr_pkg::LCR_SETUP;
					s_d.cnt   = 8'h00;
					s_d.tsel  = cmd_is_data;
					s_d.rd    = cmd_is_read;
					s_d.half  = cmd_half;
					s_d.wbyte = cmd_byte;
				end
			end
			lcr_pkg::LCR_SETUP: begin
				if (s_q.cnt == lcr_pkg::SETUP_CYC - 8'h01) begin
					s_d.st = lcr_pkg::LCR_STROBE;
				end
			end
			lcr_pkg::LCR_STROBE: begin
				if (s_q.cnt == stb_end - 8'h01) begin
					s_d.st = lcr_pkg::LCR_HOLD;
					if (s_q.rd) begin
						s_d.rvld  = 1'b1;
						s_d.rbyte = lines_s;
					end
				end
			end
			lcr_pkg::LCR_HOLD: begin
				if (s_q.cnt == stb_end + lcr_pkg::HOLD_CYC - 8'h01) begin
					s_d.st = lcr_pkg::LCR_GAP;
				end
			end
			lcr_pkg::LCR_GAP: begin
				if (s_q.cnt >= lcr_pkg::TCYC_CYC - 8'h01) begin
					s_d.st = lcr_pkg::LCR_IDLE;
				end
			end
			default: begin
				s_d.st = lcr_pkg::LCR_IDLE;
			end
		endcase
	end

	// Registers hold still while the clock enable is low.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_q    <= '0;
			s_q.st <= lcr_pkg::LCR_IDLE;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	// ==========================================================================
	// Pins
	// ==========================================================================
	logic active; // Address lines are valid from set-up through hold.

	assign active = (s_q.st == lcr_pkg::LCR_SETUP) || (s_q.st == lcr_pkg::LCR_STROBE)
		|| (s_q.st == lcr_pkg::LCR_HOLD);

	// Commands go out with select low, strobe high and write low.
	assign bus.transfer_select_pin = active && s_q.tsel;
	assign bus.read_write          = active && s_q.rd;
	assign bus.strobe              = (s_q.st == lcr_pkg::LCR_STROBE);
	assign bus.left_half_select    = active && !s_q.half;
	assign bus.right_half_select   = active && s_q.half;
	assign bus.host_byte_oe        = active && !s_q.rd;
	assign bus.host_byte_out       = s_q.wbyte;

	assign cmd_ready = (s_q.st == lcr_pkg::LCR_IDLE);
	assign rsp_valid = s_q.rvld;
	assign rsp_byte  = s_q.rbyte;

endmodule : lcr_host

//--- lcr_if.sv
// Parallel host bus between the host end and the two half controllers.
`timescale 1ns/1ps
interface lcr_if;

	// ==========================================================================
	// Pins
	// ==========================================================================
	logic             transfer_select_pin; // Low: command or status, high: data.
	logic             strobe;              // Transfer strobe, active high.
	logic             read_write;          // High: read, low: write.
	logic             left_half_select;    // Selects the segment 1 to 64 half.
	logic             right_half_select;   // Selects the segment 65 to 128 half.
	logic [7:0]       host_byte_out;       // Byte the host drives.
	logic             host_byte_oe;        // High while the host drives.
	wire  [1:0][7:0]  dev_byte_out;        // Byte each half drives.
	wire  [1:0]       dev_byte_oe;         // High while that half drives.
	logic [7:0]       host_byte_lines;     // Resolved level of the data lines.

	// The shared lines are resolved here; idle lines float high.
	always_comb begin
		if (host_byte_oe) begin
			host_byte_lines = host_byte_out;
		end else if (dev_byte_oe[0]) begin
			host_byte_lines = dev_byte_out[0];
		end else if (dev_byte_oe[1]) begin
			host_byte_lines = dev_byte_out[1];
		end else begin
			host_byte_lines = lcr_pkg::BUS_IDLE;
		end
	end

	modport host (
		output transfer_select_pin, strobe, read_write,
		output left_half_select, right_half_select,
		output host_byte_out, host_byte_oe,
		input  host_byte_lines
	);

	modport dev (
		input  transfer_select_pin, strobe, read_write,
		input  left_half_select, right_half_select,
		input  host_byte_lines,
		output dev_byte_out, dev_byte_oe
	);

endinterface : lcr_if

//--- lcr_pkg.sv
// Shared constants for the LCD command register core and its host end.
package lcr_pkg;

	// ==========================================================================
	// Clock and bus timing
	// ==========================================================================
	localparam int CLK_NS   = 4;    // Reference clock period at 250 MHz.
	localparam int T_AS_NS  = 20;   // Least address set-up before the strobe.
	localparam int T_AH_NS  = 10;   // Least address hold after the strobe.
	localparam int T_EWW_NS = 80;   // Least strobe width for a write.
	localparam int T_EWR_NS = 100;  // Least strobe width for a read.
	localparam int T_CYC_NS = 1000; // Least time from one cycle start to the next.

	// Least times round up to whole clock cycles.
	localparam logic [7:0] SETUP_CYC = 8'((T_AS_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] HOLD_CYC  = 8'((T_AH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] WR_CYC    = 8'((T_EWW_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] RD_CYC    = 8'((T_EWR_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] TCYC_CYC  = 8'((T_CYC_NS + CLK_NS - 1) / CLK_NS);

	// Cycles the device reports busy after it takes a command or data write.
	localparam logic [3:0] BUSY_CYC = 4'h8;

	// ==========================================================================
	// Register widths and reset values
	// ==========================================================================
	localparam logic       ENABLE_RST = 1'h0;
	localparam logic [5:0] ROW_RST    = 6'h00;
	localparam logic [2:0] PAGE_RST   = 3'h7;
	localparam logic [6:0] COL_RST    = 7'h00;
	localparam logic       STATIC_RST = 1'h0;
	localparam logic       DUTY_RST   = 1'h1;
	localparam logic       MAP_RST    = 1'h0;
	localparam logic [6:0] COL_LAST   = 7'h4f; // Column pointer wraps after 79.

	// ==========================================================================
	// Command codes: a byte matches when (byte & mask) == code
	// ==========================================================================
	localparam logic [7:0] CMD_DISP_MASK   = 8'hfe;
	localparam logic [7:0] CMD_DISP_CODE   = 8'hae;
	localparam logic [7:0] CMD_ROW_MASK    = 8'he0;
	localparam logic [7:0] CMD_ROW_CODE    = 8'hc0;
	localparam logic [7:0] CMD_PAGE_MASK   = 8'hfc;
	localparam logic [7:0] CMD_PAGE_CODE   = 8'hb8;
	localparam logic [7:0] CMD_COL_MASK    = 8'h80;
	localparam logic [7:0] CMD_COL_CODE    = 8'h00;
	localparam logic [7:0] CMD_MAP_MASK    = 8'hfe;
	localparam logic [7:0] CMD_MAP_CODE    = 8'ha0;
	localparam logic [7:0] CMD_STATIC_MASK = 8'hfe;
	localparam logic [7:0] CMD_STATIC_CODE = 8'ha4;
	localparam logic [7:0] CMD_DUTY_MASK   = 8'hfe;
	localparam logic [7:0] CMD_DUTY_CODE   = 8'ha8;

	// ==========================================================================
	// Status byte bit positions
	// ==========================================================================
	localparam int ST_BUSY   = 7;
	localparam int ST_MAP    = 6;
	localparam int ST_ENABLE = 5;
	localparam int ST_STATIC = 4;

	// Level the data lines float to when nobody drives them.
	localparam logic [7:0] BUS_IDLE = 8'hff;

	// Host sequencer states, Gray coded from idle through gap.
	typedef enum logic [2:0] {
		LCR_IDLE   = 3'h0,
		LCR_SETUP  = 3'h1,
		LCR_STROBE = 3'h3,
		LCR_HOLD   = 3'h2,
		LCR_GAP    = 3'h6
	} lcr_state_e;

endpackage : lcr_pkg

//--- lcr_sync.sv
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module lcr_sync #(
	parameter int W = 1 // Number of bits carried.
) (
	input  wire logic         ref_clk,
	input  wire logic         nrst,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	// ==========================================================================
	// State
	// ==========================================================================
	typedef struct packed {
		logic [W-1:0] meta; // First stage, read only by the second stage.
		logic [W-1:0] safe; // Second stage, safe for logic to read.
	} lcr_sync_s;

	lcr_sync_s s_q;
	lcr_sync_s s_d;

	// Next state shifts the pins through both stages.
	always_comb begin
		s_d      = s_q;
		s_d.meta = d;
		s_d.safe = s_q.meta;
	end

	// Registers hold still while the clock enable is low.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	assign q = s_q.safe;

endmodule : lcr_sync

//--- tb.sv
// Self-checking bench for the host end and both half controllers.
`timescale 1ns/1ps
module tb;
	// ======
	// Stimulus and observed signals
	// ======
	logic       ref_clk     = 1'b0; // 250 MHz clock.
	logic       nrst        = 1'b0; // Active low reset.
	logic       clk_en      = 1'b1; // Held high: freezing is not exercised.
	logic       cmd_valid   = 1'b0;
	logic       cmd_is_data = 1'b0;
	logic       cmd_is_read = 1'b0;
	logic       cmd_half    = 1'b0;
	logic [7:0] cmd_byte    = 8'h00;
	logic       cmd_ready;
	logic       rsp_valid;
	logic [7:0] rsp_byte;
	logic       en[2], sup[2], lp[2], duty[2], ord[2]; // Per-half flags.
	logic [5:0] row[2];
	logic [2:0] pg[2];
	logic [6:0] col[2];
	logic [7:0] st[2];
	int         err_count = 0;
	int         tests_run = 0;
	logic [7:0] got;
	int         busy;

	always #2 ref_clk = ~ref_clk;

	// ======
	// Both ends on one shared bus
	// ======
	lcr_if lcr_if_i ();
	lcr_host lcr_host_i (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .bus(lcr_if_i),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_is_data(cmd_is_data),
		.cmd_is_read(cmd_is_read), .cmd_half(cmd_half), .cmd_byte(cmd_byte),
		.rsp_valid(rsp_valid), .rsp_byte(rsp_byte));
	for (genvar h = 0; h < 2; h++) begin : g_half
		lcr_device #(.HALF(h)) lcr_device_i (.ref_clk(ref_clk), .nrst(nrst),
			.clk_en(clk_en), .bus(lcr_if_i), .display_enable(en[h]),
			.outputs_at_supply(sup[h]), .first_row_pointer(row[h]),
			.page_pointer(pg[h]), .column_pointer(col[h]), .low_power_static(lp[h]),
			.duty_choice(duty[h]), .segment_order(ord[h]), .controller_status(st[h]));
	end
	lcr_chk lcr_chk_i (.ref_clk(ref_clk), .nrst(nrst),
		.transfer_select_pin(lcr_if_i.transfer_select_pin), .strobe(lcr_if_i.strobe),
		.read_write(lcr_if_i.read_write), .left_half_select(lcr_if_i.left_half_select),
		.right_half_select(lcr_if_i.right_half_select),
		.host_byte_oe(lcr_if_i.host_byte_oe), .dev_byte_oe(lcr_if_i.dev_byte_oe));

	// ======
	// Shared tasks
	// ======
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, g, e);
		end
	endtask : chk

	// One bus transfer; returns the read byte and the busy cycles seen.
	task automatic xfer(input logic dat, rd, half, input logic [7:0] b);
		bit done;
		done = 1'b0;
		busy = 0;
		got  = 8'hxx; // Stays unknown if no answer comes, so a check fails.
		@(posedge ref_clk);
		cmd_valid   <= 1'b1;
		cmd_is_data <= dat;
		cmd_is_read <= rd;
		cmd_half    <= half;
		cmd_byte    <= b;
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		// Ready returns only after the full cycle time, so wait for it.
		for (int i = 0; i < 400 && !done; i++) begin
			@(posedge ref_clk);
			#1;
			if (rsp_valid === 1'b1) got = rsp_byte;
			if (st[half][7] === 1'b1) busy++;
			done = (cmd_ready === 1'b1) && (i > 2);
		end
		if (!done) begin
			err_count++;
			$display("wrong value at %0t: transfer never finished", $time);
			stop_test();
		end
	endtask : xfer

	task automatic do_reset();
		@(posedge ref_clk);
		nrst <= 1'b0;
		repeat (16) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge ref_clk);
	endtask : do_reset

	// ======
	// Scenarios
	// ======
	task automatic t_reset();
		for (int h = 0; h < 2; h++) begin
			chk({3'h0, en[h], sup[h], row[h], pg[h], col[h], lp[h], duty[h], ord[h], st[h]},
				{3'h0, 1'b0, 1'b1, 6'h00, 3'h7, 7'h00, 1'b0, 1'b1, 1'b0, 8'h00},
				"reset state");
		end
	endtask : t_reset

	task automatic t_display_on();
		xfer(1'b0, 1'b0, 1'b0, 8'haf);
		chk(en[0], 1, "left enable");
		chk(sup[0], 0, "left drive");
		chk(en[1], 0, "right enable");
		chk(busy, 8, "busy cycles");
		xfer(1'b0, 1'b1, 1'b0, 8'h00);
		chk(got, 8'h20, "left status");
	endtask : t_display_on

	task automatic t_right_map();
		xfer(1'b0, 1'b0, 1'b1, 8'ha1);
		chk({ord[1], ord[0]}, 2'h2, "segment order");
		xfer(1'b0, 1'b1, 1'b1, 8'h00);
		chk(got, 8'h40, "right status");
	endtask : t_right_map

	task automatic t_data_read();
		xfer(1'b1, 1'b1, 1'b0, 8'h00);
		chk(got, 8'h00, "data byte");
		chk({col[1], col[0]}, 14'h0001, "column step");
	endtask : t_data_read

	task automatic t_display_off();
		xfer(1'b0, 1'b0, 1'b0, 8'hae);
		chk({en[0], sup[0]}, 2'h1, "left off");
		xfer(1'b0, 1'b1, 1'b0, 8'h00);
		chk(got, 8'h00, "left status");
	endtask : t_display_off

	// Every other command, the column clamp and wrap, and a data write.
	// The left half is programmed; the right half must not follow it.
	task automatic t_program_all();
		xfer(1'b0, 1'b0, 1'b0, 8'hc5);
		xfer(1'b0, 1'b0, 1'b0, 8'hba);
		xfer(1'b0, 1'b0, 1'b0, 8'ha5);
		xfer(1'b0, 1'b0, 1'b0, 8'ha8);
		xfer(1'b0, 1'b0, 1'b0, 8'h7f);
		chk({row[0], pg[0], lp[0], duty[0]}, {6'h05, 3'h2, 2'h2}, "left set");
		chk(col[0], 7'h4f, "column clamp");
		chk({row[1], pg[1], lp[1], duty[1]}, {6'h00, 3'h7, 2'h1}, "right kept");
		xfer(1'b0, 1'b1, 1'b0, 8'h00);
		chk(got, 8'h10, "static status");
		xfer(1'b1, 1'b1, 1'b0, 8'h00);
		chk(col[0], 7'h00, "column wrap");
		xfer(1'b1, 1'b0, 1'b0, 8'h55);
		chk(busy, 8, "data busy");
		chk(col[0], 7'h01, "data write step");
	endtask : t_program_all

	// A reset in mid-run must undo what the host programmed.
	task automatic t_mid_reset();
		xfer(1'b0, 1'b0, 1'b1, 8'haf);
		chk(en[1], 1, "right enable");
		chk(sup[1], 0, "right drive");
		do_reset();
		t_reset();
	endtask : t_mid_reset

	initial begin
		do_reset();
		t_reset();
		t_display_on();
		t_right_map();
		t_data_read();
		t_display_off();
		t_program_all();
		t_mid_reset();
		stop_test();
	end

endmodule : tb
